// *** logic/irtc_pkg.sv ***
// Notes on behaviour
// - Reset pulse at least 12 ms, acts on release
// - Alarm output cleared within 30 ms
// - Reset operation leaves trip mode
// - Reset held: motor off, trip cleared
// - Reset function code 18 on any input
// - Reset held 4 s at power-up: comm error
// - Stop key resets only while alarmed
// - Reset terminal always normally open
// - Power-up runs the same reset sequence
// - Remote attached: stop key only briefly after power-up
// - Reset while running: motor coasts at once
// - No off-delay: outputs drop together immediately
// - Off-delay set: output holds one second
// - Run still active restarts after reset
// - Thermistor overheat trips, code reported
// - Open thermistor also trips
// - Thermistor function only on input five
// - Thermistor trip cleared by key after cooling
package irtc_pkg;

  // Clock and millisecond tick
  localparam int CLK_PERIOD_NS = 40;
  localparam int MS_IN_NS = 1_000_000;
  localparam int TICK_CYCLES = MS_IN_NS / CLK_PERIOD_NS;

  // Times in milliseconds; one tick per millisecond
  localparam logic [12:0] RESET_MIN_MS = 13'h000c;
  localparam logic [12:0] ALARM_CLR_MS = 13'h001e;
  localparam logic [12:0] CLR_AT_MS =
    (RESET_MIN_MS < ALARM_CLR_MS) ? RESET_MIN_MS : ALARM_CLR_MS;
  localparam logic [12:0] BOOT_HOLD_MS = 13'h0fa0;
  localparam logic [12:0] KEY_WINDOW_MS = 13'h0bb8;
  localparam logic [12:0] OFF_HOLD_MS = 13'h03e8;

  // Input function codes and trip codes
  localparam logic [7:0] FUNC_RESET = 8'h12;
  localparam logic [7:0] FUNC_THERM = 8'h13;
  localparam logic [7:0] OVERTEMP_TRIP_CODE = 8'h23;
  localparam logic [7:0] NO_TRIP_CODE = 8'h00;

  // Register offsets
  localparam logic [7:0] OFS_FUNC_SEL = 8'h00;
  localparam logic [7:0] OFS_FUNC_SEL5 = 8'h04;
  localparam logic [7:0] OFS_OFF_DELAY = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;

  // Reset values
  localparam logic [31:0] FUNC_SEL_RST = 32'h0000_0000;
  localparam logic [7:0] FUNC_SEL5_RST = 8'h00;
  localparam logic [23:0] OFF_DELAY_RST = 24'h00_0000;

  // Status field positions
  localparam int ST_TRIP_BIT = 0;
  localparam int ST_COMM_BIT = 1;
  localparam int ST_RSIN_BIT = 2;
  localparam int ST_KEYWIN_BIT = 3;
  localparam int ST_CODE_LSB = 8;

  // Interrupt bits
  localparam int IRQ_TRIP = 0;
  localparam int IRQ_RESET = 1;
  localparam int IRQ_COMM = 2;

  // Software settings carried together
  typedef struct packed {
    logic [7:0] input5FunctionSelect;
    logic [7:0] input4FunctionSelect;
    logic [7:0] input3FunctionSelect;
    logic [7:0] input2FunctionSelect;
    logic [7:0] input1FunctionSelect;
    logic [7:0] outputOffDelayC;
    logic [7:0] outputOffDelayB;
    logic [7:0] outputOffDelayA;
  } irtc_cfg_t;

  // Reset sequencing states
  typedef enum logic [1:0] {
    SEQ_BOOT = 2'b00,
    SEQ_NORMAL = 2'b01,
    SEQ_HELD = 2'b10
  } irtc_seq_t;

endpackage

// *** logic/irtc_reset_trip.sv ***
`timescale 1ns/1ps
module irtc_reset_trip
  import irtc_pkg::*;
#(
  parameter int TICK_COUNT = TICK_CYCLES
)
(
  input wire logic clk,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Field terminals and panel
  input wire logic [4:0] terminalIn,
  input wire logic motorThermistorOver,
  input wire logic motorThermistorOpen,
  input wire logic runCommand,
  input wire logic [2:0] logicOutRequest,
  input wire logic panelStopKey,
  input wire logic remoteStopKey,
  input wire logic remoteAnyKey,
  input wire logic remoteAttached,
  // Drive side
  output logic motorEnable,
  output logic alarmOut,
  output logic [2:0] logicOut,
  output logic [7:0] tripCode,
  output logic commError,
  output logic irq
);

  // Returns one when a count has reached its limit
  function automatic logic reached(input logic [12:0] cnt,
                                   input logic [12:0] lim);
    reached = (cnt >= lim);
  endfunction

  // Saturating millisecond step
  function automatic logic [12:0] stepSat(input logic [12:0] cnt,
                                          input logic tick);
    stepSat = (tick && cnt != 13'h1fff) ? cnt + 13'h0001 : cnt;
  endfunction

  irtc_cfg_t cfg_r; // Software settings
  irtc_seq_t seq_r; // Reset sequence state
  logic [4:0] termMeta_r; // First sync stage
  logic [4:0] termSync_r; // Second sync stage
  logic [1:0] thermMeta_r; // First sync stage, thermistor
  logic [1:0] thermSync_r; // Second sync stage, thermistor
  logic [2:0] keyMeta_r; // First sync stage, keys
  logic [2:0] keySync_r; // Second sync stage, keys
  logic [2:0] keyPrev_r; // Key history for press edges
  logic [15:0] tickCnt_r; // Cycle counter to one ms
  logic msTick_r; // One-cycle ms strobe
  logic [12:0] rsWidth_r; // Reset input on-time in ms
  logic [12:0] upTime_r; // Time since power-up in ms
  logic bootRs_r; // Reset input on since power-up
  logic trip_r; // Trip mode
  logic thermTrip_r; // Trip came from thermistor
  logic [2:0] irqStat_r; // Sticky events
  logic [2:0] irqMask_r; // Event enables
  logic rsLevel; // Any reset-assigned terminal on
  logic thermFault; // Thermistor fault on input five
  logic stopPress; // Honoured stop/reset press
  logic anyPress; // Any remote key press
  logic keyWindow; // Stop key window open
  logic resetOp; // One-cycle reset operation
  logic trEv; // Trip being entered
  logic commEv; // Comm error being raised
  logic wrEn; // APB write strobe
  logic rdEn; // APB read strobe
  logic mapped; // Address hits a register
  logic [31:0] rdVal; // Read mux

  // Synchronise terminal, thermistor and key inputs
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      termMeta_r <= 5'h00;
      termSync_r <= 5'h00;
      thermMeta_r <= 2'h0;
      thermSync_r <= 2'h0;
      keyMeta_r <= 3'h0;
      keySync_r <= 3'h0;
      keyPrev_r <= 3'h0;
    end
    else
    begin
      termMeta_r <= terminalIn;
      termSync_r <= termMeta_r;
      thermMeta_r <= {motorThermistorOpen, motorThermistorOver};
      thermSync_r <= thermMeta_r;
      keyMeta_r <= {remoteAnyKey, remoteStopKey, panelStopKey};
      keySync_r <= keyMeta_r;
      keyPrev_r <= keySync_r;
    end
  end

  // Decode terminal functions
  always_comb
  begin
    // Reset is active-on only, no polarity option
    rsLevel = (cfg_r.input1FunctionSelect == FUNC_RESET && termSync_r[0])
      | (cfg_r.input2FunctionSelect == FUNC_RESET && termSync_r[1])
      | (cfg_r.input3FunctionSelect == FUNC_RESET && termSync_r[2])
      | (cfg_r.input4FunctionSelect == FUNC_RESET && termSync_r[3])
      | (cfg_r.input5FunctionSelect == FUNC_RESET
         && termSync_r[4]);
    // Thermistor honoured on input five only
    thermFault = (cfg_r.input5FunctionSelect == FUNC_THERM)
      && (thermSync_r[0] || thermSync_r[1]);
  end

  // Key handling
  always_comb
  begin
    keyWindow = !reached(upTime_r, KEY_WINDOW_MS);
    // Stop key honoured only while alarmed, and briefly with remote
    stopPress = ((keySync_r[0] && !keyPrev_r[0])
      || (keySync_r[1] && !keyPrev_r[1]))
      && trip_r
      && (!remoteAttached || keyWindow);
    anyPress = (keySync_r[2] && !keyPrev_r[2])
      || (keySync_r[1] && !keyPrev_r[1]);
  end

  // Millisecond tick
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      tickCnt_r <= 16'h0000;
      msTick_r <= 1'b0;
    end
    else if (tickCnt_r >= 16'(TICK_COUNT - 1))
    begin
      tickCnt_r <= 16'h0000;
      msTick_r <= 1'b1;
    end
    else
    begin
      tickCnt_r <= tickCnt_r + 16'h0001;
      msTick_r <= 1'b0;
    end
  end

  // Reset pulse width and power-up time
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rsWidth_r <= 13'h0000;
      upTime_r <= 13'h0000;
    end
    else
    begin
      rsWidth_r <= rsLevel ? stepSat(rsWidth_r, msTick_r) : 13'h0000;
      upTime_r <= stepSat(upTime_r, msTick_r);
    end
  end

  // Reset sequencing
  always_ff @(posedge clk)
  begin
    if (reset)
      seq_r <= SEQ_BOOT;
    else
    begin
      case (seq_r)
        // Power-up runs the reset operation first
        SEQ_BOOT: seq_r <= rsLevel ? SEQ_HELD : SEQ_NORMAL;
        SEQ_NORMAL: seq_r <= rsLevel ? SEQ_HELD : SEQ_NORMAL;
        SEQ_HELD:
        begin
          // Act on release, only after a long enough pulse
          if (!rsLevel)
            seq_r <= reached(rsWidth_r, RESET_MIN_MS) ?
              SEQ_BOOT : SEQ_NORMAL;
        end
        default: seq_r <= SEQ_BOOT;
      endcase
    end
  end

  // Reset operation strobe
  assign resetOp = (seq_r == SEQ_BOOT);

  // Trip entry
  assign trEv = thermFault && !trip_r && !rsLevel;

  // Trip mode and code
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      trip_r <= 1'b0;
      thermTrip_r <= 1'b0;
      tripCode <= NO_TRIP_CODE;
    end
    else if (resetOp)
    begin
      // Reset operation leaves trip mode
      trip_r <= 1'b0;
      thermTrip_r <= 1'b0;
      tripCode <= NO_TRIP_CODE;
    end
    else if (rsLevel && reached(rsWidth_r, CLR_AT_MS))
    begin
      // Held input clears trip well inside the alarm limit
      trip_r <= 1'b0;
      thermTrip_r <= 1'b0;
      tripCode <= NO_TRIP_CODE;
    end
    else if (trEv)
    begin
      // Overheat or open sensor enters trip mode
      trip_r <= 1'b1;
      thermTrip_r <= 1'b1;
      tripCode <= OVERTEMP_TRIP_CODE;
    end
    else if (stopPress && !(thermTrip_r && thermFault))
    begin
      // Key clears trip once the motor has cooled
      trip_r <= 1'b0;
      thermTrip_r <= 1'b0;
      tripCode <= NO_TRIP_CODE;
    end
  end

  // Alarm raised with trip entry, so it never lags the trip code
  always_ff @(posedge clk)
  begin
    if (reset)
      alarmOut <= 1'b0;
    else
      alarmOut <= (trip_r || trEv) && !resetOp
        && !(rsLevel && reached(rsWidth_r, CLR_AT_MS));
  end

  // Motor drive
  always_ff @(posedge clk)
  begin
    if (reset)
      motorEnable <= 1'b0;
    else
      // Drive removed at once, no ramp; run restarts after reset
      motorEnable <= runCommand && !rsLevel && !trip_r && !trEv
        && !resetOp;
  end

  // Logic outputs with optional one-second hold on reset
  always_ff @(posedge clk)
  begin
    if (reset)
      logicOut <= 3'h0;
    else
    begin
      for (int i = 0; i < 3; i++)
      begin
        if (!rsLevel)
          logicOut[i] <= logicOutRequest[i];
        else if (cfg_r[i*8 +: 8] != 8'h00)
          logicOut[i] <= logicOut[i]
            && !reached(rsWidth_r, OFF_HOLD_MS);
        else
          logicOut[i] <= 1'b0;
      end
    end
  end

  // Reset input held from power-up; selectors come up unassigned, so
  // only a release or a quiet start-up window ends the watch
  always_ff @(posedge clk)
  begin
    if (reset)
      bootRs_r <= 1'b1;
    else if (!rsLevel && (seq_r == SEQ_HELD
      || reached(upTime_r, KEY_WINDOW_MS)))
      bootRs_r <= 1'b0;
  end

  // Comm error raise
  assign commEv = bootRs_r && rsLevel && !commError
    && reached(rsWidth_r, BOOT_HOLD_MS + 13'h0001);

  // Comm error shown on the remote operator only
  always_ff @(posedge clk)
  begin
    if (reset)
      commError <= 1'b0;
    else if (commEv)
      commError <= 1'b1;
    else if (!rsLevel && anyPress)
      commError <= 1'b0;
  end

  // APB strobes and decode
  assign wrEn = psel && penable && pwrite && pready;
  assign rdEn = psel && penable && !pwrite && !pready;
  assign mapped = (paddr == OFS_FUNC_SEL) || (paddr == OFS_FUNC_SEL5)
    || (paddr == OFS_OFF_DELAY) || (paddr == OFS_STATUS)
    || (paddr == OFS_IRQ_STAT) || (paddr == OFS_IRQ_MASK);

  // Settings registers
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      {cfg_r.input4FunctionSelect, cfg_r.input3FunctionSelect,
       cfg_r.input2FunctionSelect, cfg_r.input1FunctionSelect}
        <= FUNC_SEL_RST;
      cfg_r.input5FunctionSelect <= FUNC_SEL5_RST;
      {cfg_r.outputOffDelayC, cfg_r.outputOffDelayB,
       cfg_r.outputOffDelayA} <= OFF_DELAY_RST;
      irqMask_r <= 3'h0;
    end
    else if (wrEn)
    begin
      case (paddr)
        OFS_FUNC_SEL:
          {cfg_r.input4FunctionSelect, cfg_r.input3FunctionSelect,
           cfg_r.input2FunctionSelect, cfg_r.input1FunctionSelect}
            <= pwdata;
        OFS_FUNC_SEL5: cfg_r.input5FunctionSelect <= pwdata[7:0];
        OFS_OFF_DELAY:
          {cfg_r.outputOffDelayC, cfg_r.outputOffDelayB,
           cfg_r.outputOffDelayA} <= pwdata[23:0];
        OFS_IRQ_MASK: irqMask_r <= pwdata[2:0];
        default: irqMask_r <= irqMask_r;
      endcase
    end
  end

  // Sticky events, set wins over write-one-to-clear
  always_ff @(posedge clk)
  begin
    if (reset)
      irqStat_r <= 3'h0;
    else
    begin
      irqStat_r[IRQ_TRIP] <= trEv || (irqStat_r[IRQ_TRIP]
        && !(wrEn && paddr == OFS_IRQ_STAT && pwdata[IRQ_TRIP]));
      irqStat_r[IRQ_RESET] <= resetOp || (irqStat_r[IRQ_RESET]
        && !(wrEn && paddr == OFS_IRQ_STAT && pwdata[IRQ_RESET]));
      irqStat_r[IRQ_COMM] <= commEv || (irqStat_r[IRQ_COMM]
        && !(wrEn && paddr == OFS_IRQ_STAT && pwdata[IRQ_COMM]));
    end
  end

  // Interrupt level
  always_ff @(posedge clk)
  begin
    if (reset)
      irq <= 1'b0;
    else
      irq <= |(irqStat_r & irqMask_r);
  end

  // Read mux
  always_comb
  begin
    rdVal = 32'h0000_0000;
    case (paddr)
      OFS_FUNC_SEL:
        rdVal = {cfg_r.input4FunctionSelect, cfg_r.input3FunctionSelect,
                 cfg_r.input2FunctionSelect, cfg_r.input1FunctionSelect};
      OFS_FUNC_SEL5: rdVal[7:0] = cfg_r.input5FunctionSelect;
      OFS_OFF_DELAY:
        rdVal[23:0] = {cfg_r.outputOffDelayC, cfg_r.outputOffDelayB,
                       cfg_r.outputOffDelayA};
      OFS_STATUS:
      begin
        rdVal[ST_TRIP_BIT] = trip_r;
        rdVal[ST_COMM_BIT] = commError;
        rdVal[ST_RSIN_BIT] = rsLevel;
        rdVal[ST_KEYWIN_BIT] = keyWindow;
        rdVal[ST_CODE_LSB +: 8] = tripCode;
      end
      OFS_IRQ_STAT: rdVal[2:0] = irqStat_r;
      OFS_IRQ_MASK: rdVal[2:0] = irqMask_r;
      default: rdVal = 32'h0000_0000;
    endcase
  end

  // APB answer, one wait state
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !mapped;
      if (rdEn)
        prdata <= mapped ? rdVal : 32'h0000_0000;
    end
  end

endmodule

// *** sim/irtc_field_model.sv ***
`timescale 1ns/1ps
module irtc_field_model
(
  input wire logic clk,
  output logic [4:0] terminalIn,
  output logic motorThermistorOver,
  output logic motorThermistorOpen,
  output logic panelStopKey
);
  // Contacts open, sensor healthy
  initial
  begin
    terminalIn = 5'h00;
    motorThermistorOver = 1'b0;
    motorThermistorOpen = 1'b0;
    panelStopKey = 1'b0;
  end

  // Reset contact, closed means on
  task automatic set_rs(input logic v);
    terminalIn[0] <= v;
  endtask

  // Sensor verdict: hot, broken wire
  task automatic set_sense(input logic hot, input logic brk);
    motorThermistorOver <= hot;
    motorThermistorOpen <= brk;
  endtask

  // Key held a few cycles
  task automatic press_key();
    panelStopKey <= 1'b1;
    repeat (4) @(posedge clk);
    panelStopKey <= 1'b0;
  endtask
endmodule

// *** sim/irtc_reset_trip_chk.sv ***
`timescale 1ns/1ps
module irtc_reset_trip_chk
  import irtc_pkg::*;
#(
  parameter int TICK_COUNT = TICK_CYCLES
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [4:0] terminalIn,
  input wire logic motorThermistorOpen,
  input wire logic motorThermistorOver,
  input wire logic motorEnable,
  input wire logic alarmOut,
  input wire logic [7:0] tripCode,
  input wire logic irq
);
  // Alarm clear limit in cycles
  localparam int ALARM_LIM = 30 * TICK_COUNT;
  // Reset contact on-time
  logic [31:0] rsCnt_r;

  // Saturating on-time counter
  always_ff @(posedge clk)
  begin
    if (reset || !terminalIn[0])
      rsCnt_r <= '0;
    else if (rsCnt_r < 32'(ALARM_LIM))
      rsCnt_r <= rsCnt_r + 32'h0000_0001;
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  chk_code_alarm: assert property (
    tripCode != NO_TRIP_CODE |-> alarmOut)
    else $error("trip code without alarm");
  chk_trip_motor: assert property (
    alarmOut |-> !motorEnable)
    else $error("motor on while tripped");
  chk_coast_fast: assert property (
    $rose(terminalIn[0]) |-> ##[1:4] !motorEnable)
    else $error("motor kept on after reset input");
  chk_alarm_clear: assert property (
    rsCnt_r == 32'(ALARM_LIM) && !motorThermistorOver
    && !motorThermistorOpen |-> !alarmOut)
    else $error("alarm not cleared in time");
  chk_reset_quiet: assert property (
    $fell(reset) |-> !motorEnable && !alarmOut && !irq)
    else $error("outputs active after reset");
  chk_apb_answer: assert property (
    psel && penable && !pready |-> ##[0:2] pready)
    else $error("no bus answer");
  chk_ready_pulse: assert property (
    pready |=> !pready)
    else $error("ready held too long");
  chk_err_ready: assert property (
    pslverr |-> pready)
    else $error("error without ready");

  // Main scenarios reached
  cover property (alarmOut && tripCode == OVERTEMP_TRIP_CODE);
  cover property (rsCnt_r == 32'(ALARM_LIM));
  cover property (pready && pslverr);
endmodule

bind irtc_reset_trip irtc_reset_trip_chk #(.TICK_COUNT(TICK_COUNT)) chk_inst (
  .clk(clk), .reset(reset), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .terminalIn(terminalIn),
  .motorThermistorOpen(motorThermistorOpen),
  .motorThermistorOver(motorThermistorOver), .motorEnable(motorEnable),
  .alarmOut(alarmOut), .tripCode(tripCode), .irq(irq)
);

// *** sim/test_irtc_reset_trip.sv ***
`timescale 1ns/1ps
module test_irtc_reset_trip
  import irtc_pkg::*;
;
  localparam int TK = 10; // Cycles per ms
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic err;
  } irtc_row_t;
  logic clk, reset, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr, tripCode;
  logic [31:0] pwdata, prdata, rd;
  logic [4:0] terminalIn;
  logic thOver, thOpen, stopKey, remoteAttached;
  logic motorEnable, alarmOut, commError, irq;
  logic [2:0] logicOut;
  logic runCmd, remStop, anyKey;
  logic [2:0] logicReq;
  int fails = 0;
  int n_tests = 0;
  irtc_row_t rows [11];

  irtc_reset_trip #(.TICK_COUNT(TK)) irtc_reset_trip_inst (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .terminalIn(terminalIn),
    .motorThermistorOver(thOver), .motorThermistorOpen(thOpen),
    .runCommand(runCmd), .logicOutRequest(logicReq),
    .panelStopKey(stopKey), .remoteStopKey(remStop), .remoteAnyKey(anyKey),
    .remoteAttached(remoteAttached), .motorEnable(motorEnable),
    .alarmOut(alarmOut), .logicOut(logicOut), .tripCode(tripCode),
    .commError(commError), .irq(irq)
  );

  irtc_field_model irtc_field_model_inst (
    .clk(clk), .terminalIn(terminalIn), .motorThermistorOver(thOver),
    .motorThermistorOpen(thOpen), .panelStopKey(stopKey)
  );

  // Free-running clock
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Verdict and end of run
  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // One bus transfer, waits for ready
  task automatic apb(input logic [7:0] a, input logic w,
    input logic [31:0] d, output logic [31:0] r, output logic e);
    int k;
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20)
    begin
      fails++;
      close_out();
    end
    @(posedge clk);
  endtask

  // Wait whole milliseconds
  task automatic wait_ms(input int n);
    repeat (n * TK) @(posedge clk);
  endtask

  // Watchdog
  initial
  begin
    repeat (100000) @(posedge clk);
    fails++;
    close_out();
  end

  // Main sequence
  initial
  begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    remoteAttached = 1'b0;
    runCmd = 1'b1;
    logicReq = 3'b111;
    remStop = 1'b0;
    anyKey = 1'b0;
    rows = '{
      '{OFS_IRQ_STAT, 1'b0, 32'h0, 32'h0000_0002, 1'b0},
      '{OFS_IRQ_STAT, 1'b1, 32'h0000_0002, 32'h0, 1'b0},
      '{OFS_IRQ_STAT, 1'b0, 32'h0, 32'h0, 1'b0},
      '{OFS_FUNC_SEL, 1'b0, 32'h0, 32'h0, 1'b0},
      '{OFS_FUNC_SEL, 1'b1, 32'h0000_1312, 32'h0, 1'b0},
      '{OFS_FUNC_SEL, 1'b0, 32'h0, 32'h0000_1312, 1'b0},
      '{OFS_FUNC_SEL5, 1'b0, 32'h0, 32'h0, 1'b0},
      '{OFS_OFF_DELAY, 1'b1, 32'h0000_0001, 32'h0, 1'b0},
      '{OFS_IRQ_MASK, 1'b1, 32'h0000_0001, 32'h0, 1'b0},
      '{8'h18, 1'b0, 32'h0, 32'h0, 1'b1},
      '{8'h18, 1'b1, 32'hffff_ffff, 32'h0, 1'b1}};
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    repeat (4) @(posedge clk);
    chk(32'(irq), 32'h0);
    foreach (rows[i])
    begin
      apb(rows[i].addr, rows[i].wr, rows[i].wdata, rd, er);
      if (!rows[i].wr) chk(rd, rows[i].rdata);
      chk(32'(er), 32'(rows[i].err));
    end
    $display("register rows done");
    chk(32'(motorEnable), 32'h1);
    irtc_field_model_inst.set_sense(1'b1, 1'b0);
    wait_ms(1);
    chk(32'(alarmOut), 32'h0);
    apb(OFS_FUNC_SEL5, 1'b1, 32'h0000_0013, rd, er);
    wait_ms(1);
    chk(32'({alarmOut, motorEnable, irq, tripCode}), 32'h523);
    irtc_field_model_inst.press_key();
    wait_ms(1);
    chk(32'(alarmOut), 32'h1);
    irtc_field_model_inst.set_sense(1'b0, 1'b0);
    wait_ms(1);
    irtc_field_model_inst.press_key();
    wait_ms(1);
    chk(32'({alarmOut, motorEnable, tripCode}), 32'h100);
    apb(OFS_IRQ_STAT, 1'b1, 32'h0000_0007, rd, er);
    wait_ms(1);
    chk(32'(irq), 32'h0);
    $display("thermistor trip test done");
    irtc_field_model_inst.press_key();
    wait_ms(1);
    apb(OFS_IRQ_STAT, 1'b0, 32'h0, rd, er);
    chk(rd, 32'h0);
    $display("idle key test done");
    irtc_field_model_inst.set_sense(1'b0, 1'b1);
    wait_ms(1);
    chk(32'({alarmOut, tripCode}), 32'h123);
    irtc_field_model_inst.set_sense(1'b0, 1'b0);
    irtc_field_model_inst.set_rs(1'b1);
    wait_ms(1);
    chk(32'(motorEnable), 32'h0);
    wait_ms(13);
    chk(32'({alarmOut, tripCode}), 32'h0);
    irtc_field_model_inst.set_rs(1'b0);
    wait_ms(1);
    chk(32'(motorEnable), 32'h1);
    apb(OFS_IRQ_STAT, 1'b0, 32'h0, rd, er);
    chk(rd, 32'h0000_0003);
    apb(OFS_IRQ_STAT, 1'b1, 32'h0000_0003, rd, er);
    $display("reset pulse test done");
    irtc_field_model_inst.set_rs(1'b1);
    wait_ms(1);
    chk(32'({motorEnable, logicOut}), 32'h1);
    wait_ms(4);
    irtc_field_model_inst.set_rs(1'b0); // Too short to count
    wait_ms(1);
    apb(OFS_IRQ_STAT, 1'b0, 32'h0, rd, er);
    chk(rd, 32'h0);
    $display("short pulse test done");
    irtc_field_model_inst.set_rs(1'b1);
    wait_ms(500);
    chk(32'(logicOut), 32'h1);
    wait_ms(600);
    chk(32'(logicOut), 32'h0);
    irtc_field_model_inst.set_rs(1'b0);
    $display("off delay test done");
    remoteAttached <= 1'b1;
    wait_ms(3000);
    irtc_field_model_inst.set_sense(1'b1, 1'b0);
    wait_ms(1);
    irtc_field_model_inst.set_sense(1'b0, 1'b0);
    wait_ms(1);
    irtc_field_model_inst.press_key();
    wait_ms(1);
    chk(32'(alarmOut), 32'h1);
    irtc_field_model_inst.set_rs(1'b1);
    wait_ms(15);
    irtc_field_model_inst.set_rs(1'b0);
    wait_ms(1);
    chk(32'(alarmOut), 32'h0);
    $display("key window test done");
    reset <= 1'b1; // Second reset in mid-run
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    chk(32'({motorEnable, alarmOut, commError}), 32'h0);
    apb(OFS_FUNC_SEL5, 1'b1, 32'h0000_0013, rd, er);
    irtc_field_model_inst.set_sense(1'b1, 1'b0);
    wait_ms(1);
    chk(32'(alarmOut), 32'h1);
    irtc_field_model_inst.set_sense(1'b0, 1'b0);
    wait_ms(1);
    remStop <= 1'b1; // Remote key inside the start-up window
    wait_ms(1);
    remStop <= 1'b0;
    wait_ms(1);
    chk(32'(alarmOut), 32'h0);
    logicReq <= 3'b101;
    apb(OFS_FUNC_SEL, 1'b1, 32'h0000_0012, rd, er);
    chk(32'(logicOut), 32'h5);
    irtc_field_model_inst.set_rs(1'b1);
    wait_ms(1);
    chk(32'({motorEnable, logicOut}), 32'h0);
    runCmd <= 1'b0;
    wait_ms(4005);
    chk(32'({commError, alarmOut, tripCode}), 32'h200);
    apb(OFS_STATUS, 1'b0, 32'h0, rd, er);
    chk(rd, 32'h0000_0006);
    irtc_field_model_inst.set_rs(1'b0);
    wait_ms(1);
    chk(32'({commError, motorEnable}), 32'h2);
    anyKey <= 1'b1;
    wait_ms(1);
    anyKey <= 1'b0;
    wait_ms(1);
    chk(32'(commError), 32'h0);
    $display("comm error test done");
    close_out();
  end
endmodule
